// file: testbench/drc_ctrl_monitor.sv
// Purpose: Port checks on the redundancy controller
// Assumes: Bench revolution marker every 40 mclk cycles
// Notes:   Bound to every drc_ctrl instance
`timescale 1ns/1ps
module drc_ctrl_monitor (
   // Clock, reset, pins and commands
   input wire logic       mclk,
   input wire logic       resetn,
   input wire logic       north_pin,
   input wire logic [1:0] ch_fail_pin,
   input wire logic       cmd_valid,
   input wire logic [1:0] cmd_code,
   input wire logic       cmd_chan,
   input wire logic       cmd_remote,
   input wire logic       local_auth,
   input wire logic       maint_exit_remote,
   // Answers and status
   input wire logic       cmd_ack,
   input wire logic       cmd_nak,
   input wire logic [1:0] ch0_state,
   input wire logic [1:0] ch1_state,
   input wire logic       active_ch,
   input wire logic       rf_sel,
   input wire logic [1:0] fault_report,
   input wire logic       fault_event,
   input wire logic       hot_inhibit,
   input wire logic       chain_hold,
   input wire logic       sdp_lock
);
   // Revolution plus sync slack; a slower antenna needs a larger bound
   localparam int REV_CYC = 50;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Channel state, command answer, fault report and cold switch relations
   one_active_a: assert property (!(ch0_state == 2'h1 && ch1_state == 2'h1))
      else $error("both channels active");
   rf_follow_a: assert property (rf_sel == active_ch &&
      (ch1_state != 2'h1 || active_ch) && (ch0_state != 2'h1 || !active_ch))
      else $error("selection does not match active channel");
   cmd_answer_a: assert property (cmd_valid |=> cmd_ack ^ cmd_nak)
      else $error("command not answered once");
   nak_keep_a: assert property (cmd_nak && $stable(active_ch) |->
      $stable(ch0_state) && $stable(ch1_state))
      else $error("rejected command changed state");
   maint_exit_a: assert property (!($past(ch0_state) == 2'h3 &&
      ch0_state == 2'h1) && !($past(ch1_state) == 2'h3 && ch1_state == 2'h1))
      else $error("maintenance left straight to active");
   act_to_sb_a: assert property ($past(ch0_state) == 2'h1 &&
      ch0_state == 2'h0 |-> $past(chain_hold))
      else $error("active dropped without cold switch");
   hot_maint_a: assert property ($past(ch0_state) == 2'h1 &&
      ch0_state == 2'h3 |-> ch1_state == 2'h1 && hot_inhibit &&
      !$past(hot_inhibit))
      else $error("hot switch outcome wrong");
   fault_copy_a: assert property (fault_report == $past(ch_fail_pin, 3))
      else $error("fault report lags wrongly");
   cold_bound_a: assert property ($rose(chain_hold) |->
      sdp_lock ##[1:REV_CYC] !chain_hold)
      else $error("cold switch too slow or unlocked");
endmodule

bind drc_ctrl drc_ctrl_monitor u_mon (.*);

// file: testbench/drc_ops_model.sv
// Purpose: Operator and remote supervision command source
// Assumes: Caller waits for the answer before the next command
// Notes:   Code and channel are scrambled once the strobe drops
`timescale 1ns/1ps
module drc_ops_model (
   // Clock
   input  wire logic       mclk,
   // Command, exit path selection and front-panel key
   output logic            cmd_valid,
   output logic [1:0]      cmd_code,
   output logic            cmd_chan,
   output logic            cmd_remote,
   output logic            local_auth,
   output logic            maint_exit_remote
);
   // Quiet at time zero
   initial begin
      cmd_valid = 1'b0;
      {cmd_code, cmd_chan, cmd_remote} = 4'h0;
      {local_auth, maint_exit_remote} = 2'h0;
   end
   // One path level per command, so remote and local exit never both apply
   // exclusive exit path
   task automatic issue(input logic [1:0] code, input logic chan, rem, auth,
                        input logic xr);
      @(posedge mclk);
      {cmd_code, cmd_chan, cmd_remote} <= {code, chan, rem};
      {local_auth, maint_exit_remote} <= {auth, xr};
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      {cmd_code, cmd_chan} <= ~{code, chan};
   endtask
endmodule

// file: testbench/tb.sv
// Purpose: Self-checking bench for the redundancy controller
// Assumes: Revolution marker every 40 mclk cycles
// Notes:   Row bits are code, chan, remote, auth, path, ack, ch0, ch1
`timescale 1ns/1ps
module tb
   import drc_pkg::*;
;
   logic        mclk = 1'b0;
   logic        resetn, north_pin = 1'b0;
   logic [1:0]  ch_fail_pin, cmd_code, ch0_state, ch1_state, fault_report;
   logic        cmd_valid, cmd_chan, cmd_remote, local_auth, maint_exit_remote;
   logic        cmd_ack, cmd_nak, active_ch, rf_sel, fault_event, hot_inhibit;
   logic        chain_hold, sdp_lock;
   int          failures = 0, total_checks = 0, rev_cnt = 0, k;
   logic [10:0] rows [10] = '{11'h517, 11'h407, 11'h207, 11'h787, 11'h707,
                              11'h754, 11'h211, 11'h2b4, 11'h5b7, 11'h7b4};
   // 20 ns clock
   always #10 mclk = ~mclk;
   // Marker held 4 cycles so the synchroniser cannot miss it
   always @(posedge mclk) begin
      rev_cnt <= (rev_cnt == 39) ? 0 : rev_cnt + 1;
      north_pin <= (rev_cnt < 4);
   end
   drc_ops_model u_ops (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_chan(cmd_chan), .cmd_remote(cmd_remote), .local_auth(local_auth),
      .maint_exit_remote(maint_exit_remote));
   drc_ctrl DUT (.mclk(mclk), .resetn(resetn), .north_pin(north_pin),
      .ch_fail_pin(ch_fail_pin), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_chan(cmd_chan), .cmd_remote(cmd_remote), .local_auth(local_auth),
      .maint_exit_remote(maint_exit_remote), .cmd_ack(cmd_ack),
      .cmd_nak(cmd_nak), .ch0_state(ch0_state), .ch1_state(ch1_state),
      .active_ch(active_ch), .rf_sel(rf_sel), .fault_report(fault_report),
      .fault_event(fault_event), .hot_inhibit(hot_inhibit),
      .chain_hold(chain_hold), .sdp_lock(sdp_lock));
   // Compare and count
   task automatic chk(input logic [1:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Issue one command and check its answer
   task automatic cmd(input logic [10:0] r);
      int i;
      u_ops.issue(r[10:9], r[8], r[7], r[6], r[5]);
      #1;
      for (i = 0; i < 4 && (cmd_ack | cmd_nak) !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      chk({cmd_nak, cmd_ack}, {~r[4], r[4]}, "answer");
   endtask
   // Wait out a cold switch, bounded by one revolution and slack
   task automatic settle();
      int i;
      for (i = 0; i < 60 && chain_hold !== 1'b0; i++) @(posedge mclk);
      #1;
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog, far beyond the expected run of under 250 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      $display("ERROR %0t watchdog expired", $time);
      final_report();
   end
   // Main sequence
   initial begin
      resetn = 1'b0;
      ch_fail_pin = 2'h0;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      #1;
      chk(ch0_state, CH_ACTIVE, "reset ch0");
      chk({rf_sel, active_ch}, 2'h0, "reset sel");
      $display("test reset done");
      for (k = 0; k < 10; k++) begin
         cmd(rows[k]);
         settle();
         chk(ch0_state, rows[k][3:2], "ch0");
         chk(ch1_state, rows[k][1:0], "ch1");
         $display("test row %0d done", k);
      end
      @(posedge mclk) ch_fail_pin <= 2'h1;
      repeat (3) @(posedge mclk);
      #1;
      chk({fault_event, sdp_lock}, 2'h3, "hot pulse");
      repeat (3) @(posedge mclk);
      #1;
      chk(ch0_state, CH_MAINT, "hot ch0");
      chk(ch1_state, CH_ACTIVE, "hot ch1");
      chk({rf_sel, active_ch}, 2'h3, "hot sel");
      chk({hot_inhibit, fault_report[0]}, 2'h3, "hot flags");
      @(posedge mclk) ch_fail_pin <= 2'h3;
      repeat (6) @(posedge mclk);
      #1;
      chk(ch1_state, CH_ACTIVE, "second fault");
      chk(fault_report, 2'h3, "both faults");
      @(posedge mclk) ch_fail_pin <= 2'h0;
      repeat (4) @(posedge mclk);
      cmd(11'h6b1);
      chk({hot_inhibit, ch0_state[0]}, 2'h0, "exit clears");
      $display("test hot switch done");
      cmd(11'h211);
      chk({chain_hold, sdp_lock}, 2'h3, "hold");
      cmd(11'h200);
      settle();
      chk(ch0_state, CH_ACTIVE, "cold ch0");
      chk({rf_sel, active_ch}, 2'h0, "cold sel");
      $display("test back to back done");
      // Fault on active while the other is in maintenance: no switch
      cmd(11'h510);
      @(posedge mclk) ch_fail_pin <= 2'h1;
      repeat (6) @(posedge mclk);
      #1;
      chk(ch0_state, CH_ACTIVE, "no target ch0");
      chk(ch1_state, CH_MAINT, "no target ch1");
      chk({hot_inhibit, fault_report[0]}, 2'h1, "no target flags");
      $display("test no target done");
      @(posedge mclk) ch_fail_pin <= 2'h0;
      repeat (4) @(posedge mclk);
      // Mid-run reset with channel 1 still in maintenance
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk(ch1_state, RST_CH1_STATE, "in reset ch1");
      chk({chain_hold, sdp_lock}, 2'h0, "in reset hold");
      @(posedge mclk) resetn <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk(ch0_state, RST_CH0_STATE, "rerun ch0");
      chk(ch1_state, RST_CH1_STATE, "rerun ch1");
      chk(fault_report, 2'h0, "rerun faults");
      chk({hot_inhibit, fault_event}, 2'h0, "rerun flags");
      chk({cmd_ack, cmd_nak}, 2'h0, "rerun answer");
      chk({rf_sel, active_ch}, 2'h0, "rerun sel");
      $display("test mid reset done");
      final_report();
   end
endmodule

// file: verilog/drc_ctrl.sv
// Purpose: Active/stand-by/maintenance control of two redundant channels
// Assumes: north_pin pulses once per antenna revolution; fault pins are
//          levels from the channels; commands are mclk-synchronous
// Notes:   Site parameters are held outside; this block only locks them
//
// Behaviour
// - Two channels; changeover commanded locally or by remote supervision.
// - Each channel is always active, stand-by or maintenance.
// - Every channel fault is reported to remote supervision.
// - Never both channels active at once.
// - Stand-by goes active by operator cold switch or automatic hot switch.
// - Active goes to stand-by only by operator cold switch-over.
// - Maintenance entered from stand-by by command; exit always to stand-by.
// - Maintenance exit by exactly one path: remote, or authorised local.
// - Hot switch-over puts the failed channel into maintenance.
// - After a hot switch, a second hot switch is inhibited.
// - Fault-triggered switch completes within one antenna revolution.
// - Cold switch holds processing chains so no essential data is lost.
// - Cold switch completes within one revolution of command acceptance.
// - Site parameter set stays unchanged across a channel switch.
// - Active channel and RF changeover selection reported to remote station.
`timescale 1ns/1ps
module drc_ctrl
   import drc_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Antenna and channel pins
   input  wire logic       north_pin,
   input  wire logic [1:0] ch_fail_pin,
   // Operator and remote_supervision_system commands
   input  wire logic       cmd_valid,
   input  wire logic [1:0] cmd_code,
   input  wire logic       cmd_chan,
   input  wire logic       cmd_remote,
   input  wire logic       local_auth,
   input  wire logic       maint_exit_remote,
   // Command answer
   output logic            cmd_ack,
   output logic            cmd_nak,
   // Channel state reporting
   output logic [1:0]      ch0_state,
   output logic [1:0]      ch1_state,
   output logic            active_ch,
   output logic            rf_sel,
   // Fault reporting
   output logic [1:0]      fault_report,
   output logic            fault_event,
   output logic            hot_inhibit,
   // Switch-over control
   output logic            chain_hold,
   output logic            sdp_lock
);

   logic [SYNC_WIDTH-1:0] pins_s;
   logic                  north_s;
   logic [1:0]            fail_s;
   logic                  north_d_q;
   logic [1:0]            fail_d_q;
   logic                  north_tick;
   drc_chan_t             st_q [2];
   logic                  act_q;
   logic                  other;
   logic                  rf_q;
   logic                  inhibit_q;
   drc_sw_t               sw_q;
   drc_sw_t               sw_d;
   logic                  hot_go;
   logic                  legal;
   logic                  acc;
   logic                  ack_q;
   logic                  nak_q;
   logic [1:0]            rep_q;
   logic                  evt_q;
   logic                  hold_q;
   logic                  lock_q;

   // Pins from outside the mclk domain
   drc_sync #(
      .WIDTH (SYNC_WIDTH)
   ) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .pin    ({north_pin, ch_fail_pin}),
      .sync   (pins_s)
   );

   assign north_s = pins_s[SYNC_NORTH];
   assign fail_s  = pins_s[1:0];

   // Edge history on the synchronised pins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         north_d_q <= 1'b0;
         fail_d_q  <= 2'h0;
      end else begin
         north_d_q <= north_s;
         fail_d_q  <= fail_s;
      end
   end

   assign north_tick = north_s & ~north_d_q;
   assign other      = ~act_q;

   // only onto stand-by; blocked once inhibited
   assign hot_go = fail_s[act_q] && (st_q[act_q] == CH_ACTIVE) &&
                   (st_q[other] == CH_STANDBY) && !inhibit_q;

   // Command legality against current states
   always_comb begin
      legal = 1'b0;
      case (cmd_code)
         // active goes to stand-by only this way
         CMD_COLD_SWITCH: begin
            legal = (st_q[act_q] == CH_ACTIVE) &&
                    (st_q[other] == CH_STANDBY);
         end
         CMD_ENTER_MAINT: begin
            legal = (st_q[cmd_chan] == CH_STANDBY);
         end
         CMD_EXIT_MAINT: begin
            legal = (st_q[cmd_chan] == CH_MAINT) &&
                    (cmd_remote == maint_exit_remote) &&
                    (cmd_remote || local_auth);
         end
         default: begin
            legal = 1'b0;
         end
      endcase
   end

   // reject while busy or during a hot switch
   assign acc = cmd_valid && legal && (sw_q == SW_IDLE) && !hot_go;

   // Cold switch-over sequencer
   always_comb begin
      sw_d = sw_q;
      case (sw_q)
         SW_IDLE: begin
            if (acc && cmd_code == CMD_COLD_SWITCH) begin
               sw_d = SW_DRAIN;
            end
         end
         SW_DRAIN: begin
            if (hot_go) begin
               sw_d = SW_IDLE;
            end else if (north_tick) begin
               sw_d = SW_SWAP;
            end
         end
         SW_SWAP: begin
            sw_d = hot_go ? SW_IDLE : SW_RELEASE;
         end
         SW_RELEASE: begin
            sw_d = SW_IDLE;
         end
         default: begin
            sw_d = SW_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sw_q <= SW_IDLE;
      end else begin
         sw_q <= sw_d;
      end
   end

   // Channel states; hot switch wins over any other change
   // one of three states each
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_q[0] <= RST_CH0_STATE;
         st_q[1] <= RST_CH1_STATE;
         act_q   <= RST_ACTIVE_CH;
         rf_q    <= RST_ACTIVE_CH;
      end else if (hot_go) begin
         // one write swaps both, never two active
         st_q[act_q] <= CH_MAINT;
         st_q[other] <= CH_ACTIVE;
         act_q       <= other;
         rf_q        <= other;
      end else if (sw_q == SW_SWAP) begin
         st_q[act_q] <= CH_STANDBY;
         st_q[other] <= CH_ACTIVE;
         act_q       <= other;
         rf_q        <= other;
      end else if (acc && cmd_code == CMD_ENTER_MAINT) begin
         st_q[cmd_chan] <= CH_MAINT;
      end else if (acc && cmd_code == CMD_EXIT_MAINT) begin
         st_q[cmd_chan] <= CH_STANDBY;
      end
   end

   // inhibit until a channel returns from maintenance
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         inhibit_q <= 1'b0;
      end else if (hot_go) begin
         inhibit_q <= 1'b1;
      end else if (acc && cmd_code == CMD_EXIT_MAINT) begin
         inhibit_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         nak_q <= 1'b0;
      end else begin
         ack_q <= acc;
         nak_q <= cmd_valid && !acc;
      end
   end

   // fault levels and a pulse on each new fault
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rep_q <= 2'h0;
         evt_q <= 1'b0;
      end else begin
         rep_q <= fail_s;
         evt_q <= |(fail_s & ~fail_d_q);
      end
   end

   // chains held through the whole cold sequence
   // parameter writes locked during any switch
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hold_q <= 1'b0;
         lock_q <= 1'b0;
      end else begin
         hold_q <= (sw_d != SW_IDLE);
         lock_q <= (sw_d != SW_IDLE) || hot_go;
      end
   end

   // active channel and RF selection reported
   assign ch0_state    = st_q[0];
   assign ch1_state    = st_q[1];
   assign active_ch    = act_q;
   assign rf_sel       = rf_q;
   assign cmd_ack      = ack_q;
   assign cmd_nak      = nak_q;
   assign fault_report = rep_q;
   assign fault_event  = evt_q;
   assign hot_inhibit  = inhibit_q;
   assign chain_hold   = hold_q;
   assign sdp_lock     = lock_q;

endmodule

// file: verilog/drc_pkg.sv
// Purpose: Shared types and codes for the dual channel redundancy control
// Assumes: Two channels, operator commands arrive on the mclk domain
// Notes:   Channel and sequencer encodings are Gray along the usual path
package drc_pkg;

   // Per-channel operating state
   typedef enum logic [1:0] {
      CH_STANDBY = 2'h0,
      CH_ACTIVE  = 2'h1,
      CH_MAINT   = 2'h3
   } drc_chan_t;

   // Cold switch-over sequencer
   typedef enum logic [1:0] {
      SW_IDLE    = 2'h0,
      SW_DRAIN   = 2'h1,
      SW_SWAP    = 2'h3,
      SW_RELEASE = 2'h2
   } drc_sw_t;

   // Operator command codes
   localparam logic [1:0] CMD_NONE        = 2'h0;
   localparam logic [1:0] CMD_COLD_SWITCH = 2'h1;
   localparam logic [1:0] CMD_ENTER_MAINT = 2'h2;
   localparam logic [1:0] CMD_EXIT_MAINT  = 2'h3;

   // Reset configuration: channel 0 in service, channel 1 in stand-by
   localparam logic      RST_ACTIVE_CH = 1'h0;
   localparam drc_chan_t RST_CH0_STATE = CH_ACTIVE;
   localparam drc_chan_t RST_CH1_STATE = CH_STANDBY;

   // Pin synchroniser: revolution marker plus one fault line per channel
   localparam int SYNC_WIDTH = 3;
   localparam int SYNC_NORTH = 2;

endpackage

// file: verilog/drc_sync.sv
// Purpose: Two flip-flop synchroniser for asynchronous pin inputs
// Assumes: Inputs are slow levels compared with mclk
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/1ps
module drc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             resetn,
   // Pin side and synchronised side
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] sync
);

   logic [WIDTH-1:0] meta_q;

   // Two stages; the first is read only by the second
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         sync   <= '0;
      end else begin
         meta_q <= pin;
         sync   <= meta_q;
      end
   end

endmodule
